// ---- core/crd_defs.vh ----
// Offsets, field positions, revision values and timing counts of the configuration ROM block.
`ifndef CRD_DEFS_VH
`define CRD_DEFS_VH
`define CRD_ROM_TOP          12'hfff
`define CRD_COMPAT_TOP       12'h07f
`define CRD_OFF_REVISION     12'h01b
`define CRD_OFF_SLAVE        12'h0e3
`define CRD_OFF_SLAVE_USER   12'h0e7
`define CRD_OFF_MASTER       12'h0eb
`define CRD_OFF_MASTER_USER  12'h0ef
`define CRD_OFF_HANDLER      12'h0f3
`define CRD_OFF_INTERRUPTER  12'h0f7
`define CRD_OFF_WIDTH_BASE   12'h103
`define CRD_REV_ORIGINAL     8'h01
`define CRD_REV_EXTENDED     8'h02
`define CRD_BIT_UNALIGNED    7
`define CRD_BIT_RMW          6
`define CRD_BIT_ADO          5
`define CRD_BIT_ADDRESS_ONLY_HANDSHAKE_CYCLE         4
`define CRD_BIT_RETRY        3
`define CRD_BIT_SECOND_CONN  2
`define CRD_BIT_ALT_XCVR     1
`define CRD_BIT_RESERVED     0
`define CRD_AM_CONFIG        6'h2f
`define CRD_NUM_FUNCS        8
`define CRD_INIT_NS          1000
`define CRD_CLK_NS           100
`define CRD_INIT_CYCLES      ((`CRD_INIT_NS + `CRD_CLK_NS - 1) / `CRD_CLK_NS)
`endif

// ---- core/crd_config_rom.v ----
// Defined configuration ROM area with function enables gated by the module enable bit.
// How it works
// [RL1] Offsets 0x000 to 0xfff form the defined ROM area, used only for defined parameters.
// [RL2] Reserved or unimplemented locations in that area read as zero.
// [RL3] Storage may be volatile but the bus can only read it.
// [RL4] Revision byte at 0x1b reads 0x02 when extended features exist, else 0x01.
// [RL5] Slave byte bits 7..4: unaligned, read-modify-write, address-only, address-only handshake.
// [RL6] Slave byte bits 3..1: retry, second connector, alternative transceivers; bit 0 zero.
// [RL7] Master byte bits 7..4 use the same feature positions as the slave byte.
// [RL8] Master byte bits 3..1 as slave; bit 0 always zero.
// [RL9] A vendor byte follows each characteristics byte.
// [RL10] Interrupt capability masks use bits 7..1 for levels; bit 0 reserved.
// [RL11] Relocated spaces stay silent until the module enable bit is set.
// [RL12] Up to eight functions, each with parameters and a base compare register.
// [RL13] Interface stays disabled with zero base until internal initialisation ends.
// [RL14] Below 0x80 only every fourth byte holds data.
// [RL15] Contents are read-only and frozen once the board answers the bus.
// [RL16] The space is reached with address modifier 0x2f at the board's base.
// [RL17] Bus writes to the ROM area change nothing.
`timescale 1ns/1ps
`include "crd_defs.vh"
module crd_config_rom #(
	parameter                  EXTENDED       = 1,
	parameter [7:0]            SLAVE_USER     = 8'h00,
	parameter [7:0]            MASTER_USER    = 8'h00,
	parameter [7:0]            HANDLER_MASK   = 8'h00,
	parameter [7:0]            INTR_MASK      = 8'h00,
	parameter [8*`CRD_NUM_FUNCS-1:0] FUNC_WIDTHS = {`CRD_NUM_FUNCS{8'h00}}
) (
	input  wire                core_clk_i,
	input  wire                arst_n_i,
	input  wire                unaligned_transfer_support_i,
	input  wire                read_modify_write_support_i,
	input  wire                address_only_cycle_i,
	input  wire                address_only_handshake_cycle_i,
	input  wire                retry_support_i,
	input  wire                second_connector_i,
	input  wire                alternative_transceivers_i,
	input  wire                master_capable_i,
	input  wire                bus_req_i,
	input  wire                bus_write_i,
	input  wire [5:0]          bus_am_i,
	input  wire [18:0]         bus_offset_i,
	input  wire [7:0]          bus_wdata_i,
	input  wire                module_enable_i,
	input  wire                base_valid_i,
	input  wire [7:0]          func_present_i,
	output reg                 bus_ack_o,
	output reg  [7:0]          bus_rdata_o,
	output reg                 online_o,
	output reg  [7:0]          func_enable_o
);
	reg  [7:0]  slave_q;
	reg  [7:0]  master_q;
	reg  [3:0]  init_cnt_q;
	reg         init_done_q;
	reg  [7:0]  rom_d;
	reg  [3:0]  fidx;
	wire [11:0] off;
	wire [11:0] fdiff;
	// The init limit is kept wide so the compare never truncates the macro value.
	localparam [31:0] INIT_LAST = `CRD_INIT_CYCLES - 1;
	wire        in_rom;
	wire        cfg_hit;

	assign off     = bus_offset_i[11:0];
	assign fdiff   = off - `CRD_OFF_WIDTH_BASE;
	assign in_rom  = (bus_offset_i[18:12] == 7'h00); // [RL1]
	assign cfg_hit = bus_req_i && (bus_am_i == `CRD_AM_CONFIG); // [RL16]

	// Characteristics are captured each cycle until initialisation ends, one cycle before the board goes on line, then frozen.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			slave_q     <= 8'h00;
			master_q    <= 8'h00;
			init_cnt_q  <= 4'h0;
			init_done_q <= 1'b0;
		end else begin
			if (!init_done_q) begin // [RL15]
				slave_q[`CRD_BIT_UNALIGNED]   <= unaligned_transfer_support_i; // [RL5]
				slave_q[`CRD_BIT_RMW]         <= read_modify_write_support_i; // [RL5]
				slave_q[`CRD_BIT_ADO]         <= address_only_cycle_i; // [RL5]
				slave_q[`CRD_BIT_ADDRESS_ONLY_HANDSHAKE_CYCLE]        <= address_only_handshake_cycle_i; // [RL5]
				slave_q[`CRD_BIT_RETRY]       <= retry_support_i; // [RL6]
				slave_q[`CRD_BIT_SECOND_CONN] <= second_connector_i; // [RL6]
				slave_q[`CRD_BIT_ALT_XCVR]    <= alternative_transceivers_i; // [RL6]
				slave_q[`CRD_BIT_RESERVED]    <= 1'b0; // [RL6]
				if (master_capable_i) begin
					master_q[7:1] <= {unaligned_transfer_support_i, read_modify_write_support_i,
						address_only_cycle_i, address_only_handshake_cycle_i, retry_support_i,
						second_connector_i, alternative_transceivers_i}; // [RL7] [RL8]
				end else begin
					master_q[7:1] <= 7'h00;
				end
				master_q[`CRD_BIT_RESERVED] <= 1'b0; // [RL8]
			end
			if ({28'h0000000, init_cnt_q} == INIT_LAST) begin
				init_done_q <= 1'b1; // [RL13]
			end else begin
				init_cnt_q <= init_cnt_q + 4'h1;
			end
		end
	end

	always @* begin
		rom_d = 8'h00; // [RL2]
		fidx  = 4'h0;
		if (in_rom && !bus_write_i) begin // [RL3] [RL17]
			if (off <= `CRD_COMPAT_TOP && off[1:0] != 2'b11) begin
				rom_d = 8'h00; // [RL14]
			end else begin
				case (off)
					`CRD_OFF_REVISION:    rom_d = EXTENDED ? `CRD_REV_EXTENDED : `CRD_REV_ORIGINAL; // [RL4]
					`CRD_OFF_SLAVE:       rom_d = slave_q;
					`CRD_OFF_SLAVE_USER:  rom_d = SLAVE_USER; // [RL9]
					`CRD_OFF_MASTER:      rom_d = master_q;
					`CRD_OFF_MASTER_USER: rom_d = MASTER_USER; // [RL9]
					`CRD_OFF_HANDLER:     rom_d = {HANDLER_MASK[7:1], 1'b0}; // [RL10]
					`CRD_OFF_INTERRUPTER: rom_d = {INTR_MASK[7:1], 1'b0}; // [RL10]
					default: begin
						if (off >= `CRD_OFF_WIDTH_BASE && off[1:0] == 2'b11
							&& off < `CRD_OFF_WIDTH_BASE + 12'h020) begin
							fidx  = {1'b0, fdiff[4:2]};
							rom_d = FUNC_WIDTHS[fidx*8 +: 8]; // [RL12]
						end
					end
				endcase
			end
		end
	end

	// Reads answer one cycle after the request; writes are acknowledged but discarded.
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_ack_o     <= 1'b0;
			bus_rdata_o   <= 8'h00;
			online_o      <= 1'b0;
			func_enable_o <= 8'h00;
		end else begin
			bus_ack_o     <= cfg_hit && online_o; // [RL13]
			bus_rdata_o   <= (cfg_hit && online_o) ? rom_d : 8'h00; // [RL17]
			online_o      <= init_done_q;
			func_enable_o <= (init_done_q && module_enable_i && base_valid_i)
				? func_present_i : 8'h00; // [RL11] [RL12] [RL13]
		end
	end
endmodule

// ---- test/crd_rom_properties.sv ----
// Port timing checker of the configuration ROM block.
`timescale 1ns/1ps
module crd_rom_chk(input wire core_clk_i,arst_n_i,bus_req_i,bus_write_i,online_o,bus_ack_o,module_enable_i,
	input wire [5:0] bus_am_i,input wire [18:0] bus_offset_i,input wire [7:0] bus_rdata_o,func_enable_o);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	wire tk = bus_req_i && bus_am_i == 6'h2f && online_o;
	sequence s_read; tk && !bus_write_i; endsequence
	a_ack_on_take: assert property (tk |=> bus_ack_o) else $error("no answer");
	a_no_stray: assert property (!tk |=> !bus_ack_o) else $error("stray answer");
	a_write_zero: assert property (tk && bus_write_i |=> bus_rdata_o == 0) else $error("write data");
	a_above_top: assert property (tk && bus_offset_i > 19'hfff |=> bus_rdata_o == 0) else $error("above top");
	a_compat_gap: assert property (tk && bus_offset_i < 19'h80 && bus_offset_i[1:0] != 2'b11 |=> bus_rdata_o == 0)
		else $error("compat gap");
	a_revision: assert property (s_read ##0 bus_offset_i == 19'h1b |=> bus_rdata_o == 8'h02) else $error("rev");
	a_bit0_zero: assert property (s_read ##0 bus_offset_i inside {19'he3, 19'heb, 19'hf3, 19'hf7} |=> !bus_rdata_o[0])
		else $error("bit 0");
	a_idle_zero: assert property (!bus_ack_o |-> bus_rdata_o == 0) else $error("idle data");
	a_gate_off: assert property (!module_enable_i ##1 !module_enable_i |-> func_enable_o == 0) else $error("gate");
	a_online_holds: assert property (online_o |=> online_o) else $error("online dropped");
endmodule
bind crd_config_rom crd_rom_chk u_chk(.*);

// ---- test/crd_bus_master.sv ----
// Bus master model issuing configuration-space cycles and noting expected read data.
`timescale 1ns/1ps
module crd_bus_master(input wire clk_i,output reg req_o,wr_o,output reg [5:0] am_o,output reg [18:0] off_o,output reg [7:0] wd_o);
	reg [7:0] q[$];
	integer seed = 32'h2023;
	initial {req_o, wr_o, am_o, off_o, wd_o} = 0;
	// One request per edge; the design answers every held edge with AM 0x2f once on line, so back-to-back calls never idle between.
	task cyc(input r, input [18:0] a, input w, input [5:0] m, input [8:0] e);
		@(negedge clk_i);
		req_o = r;
		wr_o = w;
		am_o = m;
		off_o = a;
		wd_o = $random(seed);
		if (e[8]) q.push_back(e[7:0]);
	endtask
endmodule

// ---- test/config_rom_defined_area_test.sv ----
// Self-checking bench of the configuration ROM block.
`timescale 1ns/1ps
`define CHK(n,e,s) begin checks_done++; if ((e) !== (s)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module config_rom_defined_area_test;
	reg clk = 0, rst_n = 0, me = 0, bv = 0;
	reg [7:0] st = 8'hd6, s0, pres = 8'ha5;
	wire req, wr, ack, onl;
	wire [5:0] am;
	wire [18:0] off;
	wire [7:0] wd, rd, fe;
	integer err_count = 0, checks_done = 0, i;
	reg [31:0] rv;
	crd_config_rom #(.SLAVE_USER(8'h5a), .MASTER_USER(8'hc3), .HANDLER_MASK(8'hfe), .INTR_MASK(8'h0c)) dut(
		.core_clk_i(clk), .arst_n_i(rst_n), .unaligned_transfer_support_i(st[7]), .read_modify_write_support_i(st[6]),
		.address_only_cycle_i(st[5]), .address_only_handshake_cycle_i(st[4]), .retry_support_i(st[3]),
		.second_connector_i(st[2]), .alternative_transceivers_i(st[1]), .master_capable_i(st[0]), .bus_req_i(req),
		.bus_write_i(wr), .bus_am_i(am), .bus_offset_i(off), .bus_wdata_i(wd), .module_enable_i(me), .base_valid_i(bv),
		.func_present_i(pres), .bus_ack_o(ack), .bus_rdata_o(rd), .online_o(onl), .func_enable_o(fe));
	crd_bus_master m(.clk_i(clk), .req_o(req), .wr_o(wr), .am_o(am), .off_o(off), .wd_o(wd));
	initial forever #50 clk = ~clk;
	always @(negedge clk) if (ack === 1'b1) begin
		if (m.q.size() == 0) `CHK("unexpected ack", 1'b0, ack)
		else `CHK("rdata", m.q.pop_front(), rd)
	end
	task results;
		if (m.q.size() != 0) err_count++;
		if (err_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#300000;
		err_count++;
		results;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		m.cyc(1, 19'h1b, 0, 6'h2f, 9'h000);
		m.cyc(0, 19'h1b, 0, 6'h00, 9'h000);
		for (i = 0; i < 60 && onl !== 1'b1; i++) @(posedge clk);
		s0 = st;
		st = ~st; // Straps moved after going online must not show.
		m.cyc(1, 19'h1b, 0, 6'h2f, {1'b1, 8'h02});
		m.cyc(1, 19'h1b, 1, 6'h2f, 9'h100);
		m.cyc(1, 19'h1b, 0, 6'h2f, {1'b1, 8'h02});
		m.cyc(1, 19'h1b, 0, 6'h2e, 9'h000);
		m.cyc(1, 19'he3, 0, 6'h2f, {1'b1, s0[7:1], 1'b0});
		m.cyc(1, 19'heb, 0, 6'h2f, {1'b1, s0[0] ? {s0[7:1], 1'b0} : 8'h00});
		m.cyc(1, 19'he7, 0, 6'h2f, 9'h15a);
		m.cyc(1, 19'hef, 0, 6'h2f, 9'h1c3);
		m.cyc(1, 19'hf3, 0, 6'h2f, 9'h1fe);
		m.cyc(1, 19'hf7, 0, 6'h2f, 9'h10c);
		m.cyc(1, 19'h800, 0, 6'h2f, 9'h100);
		for (i = 0; i < 30; i++) begin
			m.cyc(1, 19'h1000 + ($random(m.seed) & 19'h7efff), 0, 6'h2f, 9'h100);
			rv = $random(m.seed);
			m.cyc(1, {12'h000, rv[4:0], 1'b0, rv[5]}, 0, 6'h2f, 9'h100);
		end
		m.cyc(0, 19'h1b, 0, 6'h00, 9'h000);
		me = 1; // Enable without programmed bases must keep decoders off.
		repeat (2) @(negedge clk);
		`CHK("fe", 8'h00, fe)
		bv = 1;
		repeat (2) @(negedge clk);
		`CHK("fe", pres, fe)
		me = 0;
		repeat (2) @(negedge clk);
		`CHK("fe", 8'h00, fe)
		results;
	end
endmodule
